// >>> design/exec_map.svh
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// register offsets
`define OFF_INSN 16'h0000
`define OFF_STAT 16'h0004
`define OFF_FLAGS 16'h0008
`define OFF_CTX 16'h000c
`define OFF_CYC 16'h0010
`define OFF_ACCA 16'h0014
`define OFF_ACCB 16'h0018
`define W_WIN 10'h001
`define A_WIN 15:6
`define A_WIDX 5:2
`define A_DMEM 15
`define A_DIDX 14:2

// bus answers
`define RESP_OK 2'b00
`define RESP_ERR 2'b10

// status flag positions
`define FL_C 0
`define FL_DC 1
`define FL_OV 2
`define FL_N 3
`define FL_Z 4

// context status fields
`define CTX_ACT 10:8
`define CTX_MAN 2:0

// opcode prefixes and fields
`define OPC_CMP 8'he7
`define OPC_SWPL 20'hfee00
`define OPC_SWPR 20'hfef00
`define OPC_DAW 20'hfd400
`define OPC_DEC 9'h1da
`define F_OP8 23:16
`define F_OP9 23:15
`define F_OP20 23:4
`define F_CMPX 15
`define F_CMPW 14:11
`define F_CMPB 10
`define F_CMPZ 9:5
`define F_S 3:0
`define F_KZ 3
`define F_K 2:0
`define F_DECB 14
`define F_DECD 13
`define F_FADR 12:0
`define TWO_WORD_BIT 24

// decimal adjust
`define BCD_MAX 4'h9
`define BCD_FIX 4'h6

// reset values and cycle counts
`define FLAGS_RST 16'h0000
`define CTX_RST 3'h0
`define CYC_ONE 4'h1
`define CYC_TWO 4'h2

`endif

// >>> design/exec_pkg.sv
package exec_pkg;

typedef enum logic [1:0] {
	ST_IDLE,
	ST_EXEC,
	ST_SWAP2
} state_t;

typedef enum logic [2:0] {
	OP_NONE,
	OP_CMP,
	OP_SWPL,
	OP_SWPR,
	OP_DAW,
	OP_DEC
} op_t;

endpackage

// >>> design/file_reg_mem.sv
`timescale 1ns/100ps
module file_reg_mem #(
	parameter int DEPTH = 8192,
	parameter int AW = 13,
	parameter int DW = 16
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];

	// registered read, old data on a write to the same word
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// >>> design/cmp_skip_ctx_bcd_dec_exec.sv
// Overview of operation
// - compare subtracts second operand from first, drops result, flags untouched
// - unequal compare flushes the next word as a no-operation
// - compare is one word, one cycle, two or three when skipping
// - compare opcode: fixed prefix, four bits first reg, four bits second reg
// - B bit zero means word, one means byte
// - literal swap takes 0 to 7 and activates an existing context
// - swap exchanges W0 to W14 and both accumulators
// - swap to a missing context is a two-cycle no-operation
// - register swap uses only the low three bits of the register
// - successful swap writes context number to both status fields
// - both swap forms are one word, two cycles
// - low nibble gets plus six when above nine or digit carry set
// - high nibble gets plus six when above nine or carry set
// - decimal adjust keeps upper byte, updates only carry
// - decimal adjust is byte-only, direct register, one word, one cycle
// - file decrement subtracts one, writes destination, sets five flags
// - destination bit zero picks W0, one picks the file register
// - file address is a 13-bit field, 0 to 8191
// - file decrement takes one cycle
`timescale 1ns/100ps
`include "exec_map.svh"
module cmp_skip_ctx_bcd_dec_exec #(
	parameter int NUM_CTX = 5,
	parameter int ACC_W = 40,
	parameter int FILE_DEPTH = 8192
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic awvalid,
	output logic awready,
	input wire logic [15:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [15:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	import exec_pkg::*;

	localparam int FA_W = $clog2(FILE_DEPTH);

	typedef struct packed {
		state_t st;
		logic aw_ok;
		logic [15:0] aw_a;
		logic w_ok;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bv;
		logic [1:0] br;
		logic rp;
		logic [15:0] ra;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
		logic [24:0] insn;
		logic skip;
		logic unk;
		logic [3:0] cyc;
		logic [2:0] tgt;
		logic [2:0] ctx;
		logic [2:0] mctx;
		logic [15:0] sr;
		logic [15:0] w15;
		logic [NUM_CTX-1:0][14:0][15:0] wr;
		logic [NUM_CTX-1:0][ACC_W-1:0] acca;
		logic [NUM_CTX-1:0][ACC_W-1:0] accb;
	} regs_t;

	regs_t q_r;
	regs_t q_nxt;
	logic commit;
	logic mem_we;
	logic [FA_W-1:0] mem_a;
	logic [15:0] mem_wd;
	logic [15:0] mem_rd;
	op_t op;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
		end
	endfunction

	// working register of the active context, W15 shared
	function automatic logic [15:0] rdw(input logic [3:0] i);
		return (i == 4'hf) ? q_r.w15 : q_r.wr[q_r.ctx][i];
	endfunction

	function automatic op_t decode(input logic [23:0] i);
		if (i[`F_OP8] == `OPC_CMP && !i[`F_CMPX] && i[`F_CMPZ] == 5'h00) begin
			return OP_CMP;
		end else if (i[`F_OP20] == `OPC_SWPL && !i[`F_KZ]) begin
			return OP_SWPL;
		end else if (i[`F_OP20] == `OPC_SWPR) begin
			return OP_SWPR;
		end else if (i[`F_OP20] == `OPC_DAW) begin
			return OP_DAW;
		end else if (i[`F_OP9] == `OPC_DEC) begin
			return OP_DEC;
		end
		return OP_NONE;
	endfunction

	file_reg_mem #(
		.DEPTH(FILE_DEPTH),
		.AW(FA_W),
		.DW(16)
	) u_mem (
		.clk(clk),
		.we(mem_we),
		.addr(mem_a),
		.wdata(mem_wd),
		.rdata(mem_rd)
	);

	assign op = decode(q_r.insn[23:0]);
	assign commit = q_r.aw_ok && q_r.w_ok && !q_r.bv && q_r.st == ST_IDLE;
	assign awready = !q_r.aw_ok;
	assign wready = !q_r.w_ok;
	assign arready = q_r.st == ST_IDLE && !commit && !q_r.rp && !q_r.rv;
	assign bvalid = q_r.bv;
	assign bresp = q_r.br;
	assign rvalid = q_r.rv;
	assign rdata = q_r.rd;
	assign rresp = q_r.rr;

	always_comb begin
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] v;
		logic [15:0] res;
		logic [15:0] dst;
		logic [8:0] sum;
		logic lo_f;
		logic hi_f;
		logic byt;
		logic [3:0] wi;
		logic [31:0] m;
		a = 16'h0000;
		b = 16'h0000;
		v = 16'h0000;
		res = 16'h0000;
		dst = 16'h0000;
		sum = 9'h000;
		lo_f = 1'b0;
		hi_f = 1'b0;
		byt = 1'b0;
		wi = 4'h0;
		m = 32'h0000_0000;
		q_nxt = q_r;
		mem_we = 1'b0;
		mem_a = FA_W'(araddr[`A_DIDX]);
		mem_wd = 16'h0000;

		// address and data channels taken in either order
		if (!q_r.aw_ok && awvalid) begin
			q_nxt.aw_ok = 1'b1;
			q_nxt.aw_a = awaddr;
		end
		if (!q_r.w_ok && wvalid) begin
			q_nxt.w_ok = 1'b1;
			q_nxt.w_d = wdata;
			q_nxt.w_s = wstrb;
		end
		if (q_r.bv && bready) begin
			q_nxt.bv = 1'b0;
		end
		if (q_r.rv && rready) begin
			q_nxt.rv = 1'b0;
		end

		// register write
		if (commit) begin
			q_nxt.aw_ok = 1'b0;
			q_nxt.w_ok = 1'b0;
			q_nxt.bv = 1'b1;
			q_nxt.br = `RESP_OK;
			wi = q_r.aw_a[`A_WIDX];
			if (q_r.aw_a[`A_DMEM]) begin
				m = merge({16'h0000, mem_rd}, q_r.w_d, q_r.w_s);
				mem_we = 1'b1;
				mem_a = FA_W'(q_r.aw_a[`A_DIDX]);
				mem_wd = m[15:0];
			end else if (q_r.aw_a[`A_WIN] == `W_WIN) begin
				m = merge({16'h0000, rdw(wi)}, q_r.w_d, q_r.w_s);
				if (wi == 4'hf) begin
					q_nxt.w15 = m[15:0];
				end else begin
					q_nxt.wr[q_r.ctx][wi] = m[15:0];
				end
			end else begin
				unique case (q_r.aw_a)
					`OFF_INSN: begin
						q_nxt.insn = q_r.w_d[24:0];
						q_nxt.st = ST_EXEC;
						// fetch the file operand ahead of execution
						mem_a = FA_W'(q_r.w_d[`F_FADR]);
					end
					`OFF_FLAGS: begin
						m = merge({16'h0000, q_r.sr}, q_r.w_d, q_r.w_s);
						q_nxt.sr = m[15:0];
					end
					`OFF_ACCA: begin
						m = merge(q_r.acca[q_r.ctx][31:0], q_r.w_d, q_r.w_s);
						q_nxt.acca[q_r.ctx] = ACC_W'(signed'(m));
					end
					`OFF_ACCB: begin
						m = merge(q_r.accb[q_r.ctx][31:0], q_r.w_d, q_r.w_s);
						q_nxt.accb[q_r.ctx] = ACC_W'(signed'(m));
					end
					`OFF_STAT, `OFF_CTX, `OFF_CYC: begin
						q_nxt.br = `RESP_OK;
					end
					default: begin
						q_nxt.br = `RESP_ERR;
					end
				endcase
			end
		end

		// register read, answered one cycle after capture
		if (arvalid && arready) begin
			q_nxt.rp = 1'b1;
			q_nxt.ra = araddr;
		end
		if (q_r.rp) begin
			q_nxt.rp = 1'b0;
			q_nxt.rv = 1'b1;
			q_nxt.rr = `RESP_OK;
			q_nxt.rd = 32'h0000_0000;
			if (q_r.ra[`A_DMEM]) begin
				q_nxt.rd = {16'h0000, mem_rd};
			end else if (q_r.ra[`A_WIN] == `W_WIN) begin
				q_nxt.rd = {16'h0000, rdw(q_r.ra[`A_WIDX])};
			end else begin
				unique case (q_r.ra)
					`OFF_INSN: q_nxt.rd = {7'h00, q_r.insn};
					`OFF_STAT: q_nxt.rd = {29'h0, q_r.unk, q_r.skip, q_r.st != ST_IDLE};
					`OFF_FLAGS: q_nxt.rd = {16'h0000, q_r.sr};
					`OFF_CTX: q_nxt.rd = {21'h0, q_r.ctx, 5'h00, q_r.mctx};
					`OFF_CYC: q_nxt.rd = {28'h0, q_r.cyc};
					`OFF_ACCA: q_nxt.rd = q_r.acca[q_r.ctx][31:0];
					`OFF_ACCB: q_nxt.rd = q_r.accb[q_r.ctx][31:0];
					default: q_nxt.rr = `RESP_ERR;
				endcase
			end
		end

		// execution
		unique case (q_r.st)
			ST_IDLE: begin
			end
			ST_EXEC: begin
				q_nxt.st = ST_IDLE;
				q_nxt.unk = 1'b0;
				if (q_r.skip) begin
					// flushed word runs as a no-operation
					q_nxt.skip = q_r.insn[`TWO_WORD_BIT];
					q_nxt.cyc = q_r.cyc + 4'h1;
				end else begin
					q_nxt.cyc = `CYC_ONE;
					unique case (op)
						OP_CMP: begin
							a = rdw(q_r.insn[`F_CMPW]);
							b = rdw(q_r.insn[`F_S]);
							res = a - b;
							if (q_r.insn[`F_CMPB]) begin
								q_nxt.skip = res[7:0] != 8'h00;
							end else begin
								q_nxt.skip = res != 16'h0000;
							end
						end
						OP_SWPL: begin
							q_nxt.tgt = q_r.insn[`F_K];
							q_nxt.st = ST_SWAP2;
							q_nxt.cyc = `CYC_TWO;
						end
						OP_SWPR: begin
							v = rdw(q_r.insn[`F_S]);
							q_nxt.tgt = v[2:0];
							q_nxt.st = ST_SWAP2;
							q_nxt.cyc = `CYC_TWO;
						end
						OP_DAW: begin
							v = rdw(q_r.insn[`F_S]);
							lo_f = v[3:0] > `BCD_MAX || q_r.sr[`FL_DC];
							hi_f = v[7:4] > `BCD_MAX || q_r.sr[`FL_C];
							sum = {1'b0, v[7:0]} + {1'b0, hi_f ? `BCD_FIX : 4'h0,
								lo_f ? `BCD_FIX : 4'h0};
							res = {v[15:8], sum[7:0]};
							q_nxt.sr[`FL_C] = sum[8] | q_r.sr[`FL_C];
							wi = q_r.insn[`F_S];
							if (wi == 4'hf) begin
								q_nxt.w15 = res;
							end else begin
								q_nxt.wr[q_r.ctx][wi] = res;
							end
						end
						OP_DEC: begin
							byt = q_r.insn[`F_DECB];
							res = mem_rd - 16'h0001;
							dst = q_r.insn[`F_DECD] ? mem_rd : rdw(4'h0);
							q_nxt.sr[`FL_DC] = mem_rd[3:0] != 4'h0;
							if (byt) begin
								dst = {dst[15:8], res[7:0]};
								q_nxt.sr[`FL_C] = mem_rd[7:0] != 8'h00;
								q_nxt.sr[`FL_Z] = res[7:0] == 8'h00;
								q_nxt.sr[`FL_N] = res[7];
								q_nxt.sr[`FL_OV] = mem_rd[7:0] == 8'h80;
							end else begin
								dst = res;
								q_nxt.sr[`FL_C] = mem_rd != 16'h0000;
								q_nxt.sr[`FL_Z] = res == 16'h0000;
								q_nxt.sr[`FL_N] = res[15];
								q_nxt.sr[`FL_OV] = mem_rd == 16'h8000;
							end
							if (q_r.insn[`F_DECD]) begin
								mem_we = 1'b1;
								mem_a = FA_W'(q_r.insn[`F_FADR]);
								mem_wd = dst;
							end else begin
								q_nxt.wr[q_r.ctx][0] = dst;
							end
						end
						OP_NONE: begin
							q_nxt.unk = 1'b1;
						end
					endcase
				end
			end
			ST_SWAP2: begin
				q_nxt.st = ST_IDLE;
				// each context owns its W0-W14 and accumulators
				if (32'(q_r.tgt) < NUM_CTX) begin
					q_nxt.ctx = q_r.tgt;
					q_nxt.mctx = q_r.tgt;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q_r <= '0;
			q_r.st <= ST_IDLE;
			q_r.sr <= `FLAGS_RST;
			q_r.ctx <= `CTX_RST;
			q_r.mctx <= `CTX_RST;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule

// >>> verif/exec_bus_properties.sv
`timescale 1ns/100ps
`include "exec_map.svh"
module exec_bus_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// bus steps
	sequence s_ar_taken; arvalid && arready; endsequence
	sequence s_r_answer; !rvalid ##1 rvalid; endsequence
	sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
	property p_read_latency; s_ar_taken |=> s_r_answer; endproperty
	a_read_latency: assert property (p_read_latency) else $error("read answer off time");
	property p_write_answer; s_wr_taken |-> ##[1:8] bvalid; endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_r_drop; rvalid && rready |=> !rvalid; endproperty
	a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_b_drop; bvalid && bready |=> !bvalid; endproperty
	a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
	property p_ar_block; rvalid |-> !arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while answered");
	property p_err_zero; rvalid && rresp == `RESP_ERR |-> rdata == 32'h0; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error read carries data");
endmodule
bind cmp_skip_ctx_bcd_dec_exec exec_bus_checker u_exec_bus_checker (.clk, .reset, .awvalid,
	.awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready,
	.rdata, .rresp);

// >>> verif/tb.sv
`timescale 1ns/100ps
`include "exec_map.svh"
module tb;
	typedef struct packed {
		logic [15:0] pa;
		logic [15:0] pv;
		logic [15:0] fi;
		logic [31:0] insn;
		logic [15:0] ca;
		logic [15:0] ev;
		logic [15:0] fe;
	} row_t;
	logic clk = 1'h0, reset = 1'h1;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [15:0] awaddr = 16'h0, araddr = 16'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, got;
	int miscompares = 0, checked = 0;
	// address, value, flags in, word, address read, value, flags out
	row_t rows [9] = '{
		'{16'h0044, 16'h771a, 16'h0002, 32'hfd4001, 16'h0044, 16'h7720, 16'h0002},
		'{16'h004c, 16'h77aa, 16'h0000, 32'hfd4003, 16'h004c, 16'h7710, 16'h0001},
		'{16'h007c, 16'h1234, 16'h0001, 32'hfd400f, 16'h007c, 16'h1294, 16'h0001},
		'{16'h0048, 16'h0099, 16'h0002, 32'hfd4002, 16'h0048, 16'h009f, 16'h0002},
		'{16'hfffc, 16'h8000, 16'h0000, 32'hed3fff, 16'hfffc, 16'h7fff, 16'h0005},
		'{16'h8000, 16'h1280, 16'h0000, 32'hed6000, 16'h8000, 16'h127f, 16'h0005},
		'{16'h8014, 16'h0001, 16'h0000, 32'hed0005, 16'h0040, 16'h0000, 16'h0013},
		'{16'h8008, 16'h0000, 16'h0000, 32'hed2002, 16'h8008, 16'hffff, 16'h0008},
		'{16'h8018, 16'h5510, 16'h0000, 32'hed4006, 16'h0040, 16'h000f, 16'h0001}
	};

	always #50 clk = ~clk;

	cmp_skip_ctx_bcd_dec_exec u_cmp_skip_ctx_bcd_dec_exec (.clk, .reset, .awvalid, .awready,
		.awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp);

	task automatic chk_data(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e = `RESP_OK);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		chk_resp("write response", e, bresp);
		@(posedge clk);
	endtask

	task automatic rd(input logic [15:0] a, input logic [1:0] e);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
		got = rdata;
		chk_resp("read response", e, rresp);
		@(posedge clk);
	endtask

	task automatic rc(input logic [15:0] a, input logic [31:0] e);
		rd(a, `RESP_OK);
		chk_data($sformatf("register %h", a), e, got);
	endtask

	task automatic complete_run();
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		rc(`OFF_FLAGS, 32'h0);
		rc(`OFF_CTX, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].pa, {16'h0, rows[i].pv});
			wr(`OFF_FLAGS, {16'h0, rows[i].fi});
			wr(`OFF_INSN, rows[i].insn);
			rc(rows[i].ca, {16'h0, rows[i].ev});
			rc(`OFF_FLAGS, {16'h0, rows[i].fe});
		end
		rc(`OFF_CYC, 32'h1);
		rc(16'h8018, 32'h5510);
		wr(16'h0048, 32'h11ff);
		wr(16'h004c, 32'h22fe);
		wr(`OFF_FLAGS, 32'h1);
		wr(`OFF_INSN, 32'he71403);
		rc(`OFF_STAT, 32'h2);
		rc(`OFF_FLAGS, 32'h1);
		rc(`OFF_CYC, 32'h1);
		wr(`OFF_INSN, 32'hed2000);
		rc(16'h8000, 32'h127f);
		rc(`OFF_CYC, 32'h2);
		wr(16'h004c, 32'h22ff);
		wr(`OFF_INSN, 32'he71403);
		rc(`OFF_STAT, 32'h0);
		wr(`OFF_INSN, 32'hfd4001);
		rc(16'h0044, 32'h7780);
		wr(`OFF_INSN, 32'he71003);
		wr(`OFF_INSN, 32'h1fd4001);
		wr(`OFF_INSN, 32'hfd4001);
		rc(16'h0044, 32'h7780);
		rc(`OFF_CYC, 32'h3);
		wr(`OFF_ACCA, 32'h12345678);
		wr(`OFF_ACCB, 32'h80000001);
		wr(`OFF_INSN, 32'hfee004);
		rc(`OFF_CTX, 32'h404);
		rc(16'h0044, 32'h0);
		rc(`OFF_ACCA, 32'h0);
		rc(`OFF_ACCB, 32'h0);
		rc(16'h007c, 32'h1294);
		rc(`OFF_CYC, 32'h2);
		wr(16'h0050, 32'hfff8);
		wr(`OFF_INSN, 32'hfef004);
		rc(`OFF_CTX, 32'h0);
		rc(16'h0044, 32'h7780);
		rc(`OFF_ACCA, 32'h12345678);
		rc(`OFF_ACCB, 32'h80000001);
		wr(16'h0050, 32'h5);
		wr(`OFF_INSN, 32'hfef004);
		rc(`OFF_CTX, 32'h0);
		rc(`OFF_CYC, 32'h2);
		wr(`OFF_INSN, 32'he71423);
		rc(`OFF_STAT, 32'h4);
		rc(`OFF_INSN, 32'he71423);
		rc(`OFF_CYC, 32'h1);
		rd(16'h0020, `RESP_ERR);
		chk_data("unmapped read", 32'h0, got);
		wr(16'h0020, 32'h1, `RESP_ERR);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		rc(16'h0044, 32'h0);
		complete_run();
	end
endmodule
